// *** bench/tap_tester.sv ***
// Behavioural test controller that drives the test clock, mode select, data in and test reset.
// Assumes the port puts tdo out within half a test clock period after each falling edge.
`timescale 1ns/1ps
module tap_tester (
    output logic tck, // Test clock, idle low between frames
    output logic tms, // Mode select
    output logic tdi, // Serial data to the port
    output logic trst_n, // Test reset, active low
    input wire logic tdo // Serial data from the port
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end
    // One period of 48 ns; tdo is taken just before the rise
    task automatic tick(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #23;
        q = tdo;
        #1 tck = 1'b1;
        #24 tck = 1'b0;
    endtask
    // Mode select bits are applied lsb first
    task automatic walk(input logic [7:0] path, input int n);
        logic q;
        for (int i = 0; i < n; i++) tick(path[i], 1'b0, q);
    endtask
    task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
        walk(8'h01, 2);
    endtask
    task automatic scan_ir(input logic [3:0] code, output logic [3:0] cap);
        logic [31:0] q;
        walk(8'h03, 4);
        shift(4, {28'h0, code}, q);
        cap = q[3:0];
    endtask
    task automatic scan_dr(input logic [31:0] din, output logic [31:0] dout);
        walk(8'h01, 3);
        shift(32, din, dout);
    endtask
    task automatic idle_reset();
        walk(8'h1f, 6);
    endtask
    task automatic line_reset();
        trst_n = 1'b0;
        #60 trst_n = 1'b1;
        #60;
    endtask
endmodule

// *** bench/test_boundary_scan_test_port.sv ***
// Self-checking bench for the boundary scan test port, one row per instruction.
// Assumes the design include path and the tap_tester partner model.
`timescale 1ns/1ps
`include "scan_port_defines.svh"
`define CHECK(what, exp, got) begin \
    checked++; \
    if ((got) !== (exp)) begin \
        $display("wrong value %s expected %h seen %h", what, exp, got); \
        errors++; \
    end \
end
module test_boundary_scan_test_port;
    typedef struct {logic [3:0] code; int len; int mode;} row_t;
    // Pin mode: 0 core drives, 1 boundary cells drive, 2 drivers off
    row_t rows[6] = '{'{4'h1, 17, 0}, '{4'h0, 17, 1}, '{4'h3, 1, 1},
        '{4'h4, 1, 2}, '{4'h2, 32, 0}, '{4'hf, 1, 0}};
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] pin_in = 8'h5c;
    logic [7:0] core_out = 8'h3b;
    logic core_oe = 1'b1;
    wire tck;
    wire tms;
    wire tdi;
    wire trst_n;
    logic tdo;
    logic tdo_oe;
    logic [7:0] core_in;
    logic [7:0] pin_out;
    logic pin_oe;
    int errors = 0;
    int checked = 0;
    logic [16:0] cells = '0;
    logic [31:0] din;
    logic [31:0] dout;
    logic [3:0] cap;

    always #2.5 ref_clk = ~ref_clk;

    tap_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

    scan_port dut (.ref_clk(ref_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_in(core_in),
        .core_out(core_out), .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe));

    task automatic tally_and_finish();
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check_pins(input int mode);
        @(negedge ref_clk);
        if (mode == 2) begin
            `CHECK("pin_oe", 1'b0, pin_oe)
        end else if (mode == 1) begin
            `CHECK("pin_out", cells[15:8], pin_out)
            `CHECK("pin_oe", cells[16], pin_oe)
        end else begin
            `CHECK("pin_out", core_out, pin_out)
            `CHECK("pin_oe", core_oe, pin_oe)
        end
    endtask

    task automatic read_id(input string what);
        tester.walk(8'h00, 1);
        tester.scan_dr(32'h0f0f_3c3c, dout);
        `CHECK(what, `ID_VALUE, dout)
        `CHECK("id present", 1'b1, dout[0])
        `CHECK("tdo_oe", 1'b0, tdo_oe)
    endtask

    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        #1 reset = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        read_id("id after reset");
        foreach (rows[i]) begin
            @(posedge ref_clk);
            #1;
            core_out = core_out + 8'h51;
            core_oe = ~core_oe;
            pin_in = pin_in + 8'h13;
            din = 32'h9e37_79b9 * (i + 1);
            tester.scan_ir(rows[i].code, cap);
            `CHECK("ir capture", `IR_CAPTURE, cap)
            `CHECK("core_in", pin_in, core_in)
            check_pins(rows[i].mode);
            tester.scan_dr(din, dout);
            if (rows[i].len == 32) begin
                `CHECK("id", `ID_VALUE, dout)
            end else begin
                `CHECK("tail", (din << rows[i].len) >> rows[i].len, dout >> rows[i].len)
            end
            if (rows[i].len == 1) begin
                `CHECK("bypass capture", 1'b0, dout[0])
            end
            if (rows[i].len == 17) begin
                `CHECK("input cells", pin_in, dout[7:0])
                `CHECK("output cells", (rows[i].mode == 1) ? cells[15:8] : core_out,
                    dout[15:8])
            end
            if (rows[i].code <= 4'h1) begin
                cells = din[31:15];
            end
            check_pins(rows[i].mode);
        end
        tester.idle_reset();
        tester.scan_dr(32'h1234_5678, dout);
        `CHECK("id after tms reset", `ID_VALUE, dout)
        tester.scan_ir(4'hf, cap);
        tester.walk(8'h01, 3);
        tester.walk(8'h00, 5);
        tester.line_reset();
        read_id("id after test reset");
        tally_and_finish();
    end
endmodule

// *** verilog/boundary_chain.sv ***
// Boundary cells: capture/shift register and update register.
// Assumes one-cycle capture, shift and update enables from the port controller.
`timescale 1ns/1ps
`include "scan_port_defines.svh"
module boundary_chain (
    input wire logic ref_clk, // System clock
    input wire logic reset, // Asynchronous reset, active high
    input wire logic cap_en, // Load parallel values into the cells
    input wire logic shift_en, // Shift one cell toward ser_out
    input wire logic upd_en, // Copy shift cells to update cells
    input wire logic ser_in, // Serial data in
    input wire logic [`BND_LEN-1:0] par_in, // Values seen at the pins
    output logic ser_out, // Serial data out
    output logic [`BND_LEN-1:0] upd_out // Update cells
);
    import scan_port_pkg::*;

    scan_port_pkg::chain_state_t st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (cap_en) begin
            nxt_st.sr = par_in;
        end else if (shift_en) begin
            nxt_st.sr = {ser_in, st_ff.sr[`BND_LEN-1:1]};
        end
        if (upd_en) begin
            nxt_st.upd = st_ff.sr;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ser_out = st_ff.sr[0];
    assign upd_out = st_ff.upd;
endmodule

// *** verilog/pin_sync.sv ***
// Two-flop synchroniser for the test pins and functional inputs.
// Assumes all inputs are asynchronous to ref_clk.
`timescale 1ns/1ps
`include "scan_port_defines.svh"
module pin_sync (
    input wire logic ref_clk, // System clock
    input wire logic reset, // Asynchronous reset, active high
    input wire logic [`SYNC_W-1:0] d_in, // Asynchronous inputs
    output logic [`SYNC_W-1:0] d_out // Synchronised inputs
);
    import scan_port_pkg::*;

    scan_port_pkg::sync_state_t st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = d_in;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign d_out = st_ff.s2;
endmodule

// *** verilog/scan_port.sv ***
// Boundary scan test access port: controller, instruction, bypass, id and chain.
// Assumes test pins arrive asynchronously; tck is sampled by ref_clk.
`timescale 1ns/1ps
`include "scan_port_defines.svh"
module scan_port (
    input wire logic ref_clk, // System clock, 200 MHz
    input wire logic reset, // Asynchronous reset, active high
    input wire logic tck, // Test clock pin
    input wire logic tms, // Test mode select pin
    input wire logic tdi, // Test data in pin
    input wire logic trst_n, // Test reset pin, active low
    output logic tdo, // Test data out
    output logic tdo_oe, // Test data out enable
    input wire logic [`BND_IN_W-1:0] pin_in, // Functional input pins
    output logic [`BND_IN_W-1:0] core_in, // Functional inputs to the core
    input wire logic [`BND_OUT_W-1:0] core_out, // Functional outputs from the core
    input wire logic core_oe, // Output enable from the core
    output logic [`BND_OUT_W-1:0] pin_out, // Functional output pins
    output logic pin_oe // Functional output pin enable
);
    import scan_port_pkg::*;

    scan_port_pkg::port_state_t st_ff, nxt_st;
    logic [`SYNC_W-1:0] sync_out;
    logic tck_s, tms_s, tdi_s, trst_n_s;
    logic [`BND_IN_W-1:0] pin_in_s;
    logic tck_rise, tck_fall;
    logic bnd_sel, bnd_ser, bnd_cap, bnd_shift, bnd_upd;
    logic [`BND_LEN-1:0] bnd_par, bnd_cells;
    logic dr_out;

    function automatic tap_t next_tap(input tap_t s, input logic m);
        case (s)
            TAP_TLR: next_tap = m ? TAP_TLR : TAP_IDLE;
            TAP_IDLE: next_tap = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_tap = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_tap = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_tap = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: next_tap = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_tap = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: next_tap = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: next_tap = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: next_tap = m ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: next_tap = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_tap = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: next_tap = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_tap = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: next_tap = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: next_tap = m ? TAP_SEL_DR : TAP_IDLE;
            default: next_tap = TAP_TLR;
        endcase
    endfunction

    // Instructions whose update cells drive the functional pins
    function automatic logic cells_drive(input logic [`IR_W-1:0] ins);
        cells_drive = (ins == `INS_EXTEST) || (ins == `INS_CLAMP);
    endfunction

    // Instructions that put the boundary chain in the serial path
    function automatic logic chain_path(input logic [`IR_W-1:0] ins);
        chain_path = (ins == `INS_EXTEST) || (ins == `INS_SAMPLE);
    endfunction

    pin_sync u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .d_in({pin_in, trst_n, tdi, tms, tck}),
        .d_out(sync_out)
    );

    assign tck_s = sync_out[0];
    assign tms_s = sync_out[1];
    assign tdi_s = sync_out[2];
    assign trst_n_s = sync_out[3];
    assign pin_in_s = sync_out[`SYNC_W-1:4];
    assign core_in = pin_in;

    assign tck_rise = tck_s & ~st_ff.tck_prev;
    assign tck_fall = ~tck_s & st_ff.tck_prev;

    // Chain sees every functional input and output, test pins excluded
    assign bnd_par = {st_ff.pin_oe, st_ff.pin_out, pin_in_s};
    assign bnd_sel = chain_path(st_ff.ir);
    assign bnd_cap = tck_rise && (st_ff.state == TAP_CAP_DR) && bnd_sel;
    assign bnd_shift = tck_rise && (st_ff.state == TAP_SHIFT_DR) && bnd_sel;
    assign bnd_upd = tck_fall && (st_ff.state == TAP_UPD_DR) && bnd_sel;

    boundary_chain u_chain (
        .ref_clk(ref_clk),
        .reset(reset),
        .cap_en(bnd_cap),
        .shift_en(bnd_shift),
        .upd_en(bnd_upd),
        .ser_in(tdi_s),
        .par_in(bnd_par),
        .ser_out(bnd_ser),
        .upd_out(bnd_cells)
    );

    // Serial path select; reserved codes fall back to the bypass bit
    always_comb begin
        if (bnd_sel) begin
            dr_out = bnd_ser;
        end else if (st_ff.ir == `INS_IDCODE) begin
            dr_out = st_ff.id_sr[0];
        end else begin
            dr_out = st_ff.byp;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tck_prev = tck_s;
        if (tck_rise) begin
            nxt_st.state = next_tap(st_ff.state, tms_s);
            case (st_ff.state)
                TAP_CAP_IR: begin
                    nxt_st.ir_sr = `IR_CAPTURE;
                end
                TAP_SHIFT_IR: begin
                    nxt_st.ir_sr = {tdi_s, st_ff.ir_sr[`IR_W-1:1]};
                end
                TAP_CAP_DR: begin
                    nxt_st.byp = 1'b0;
                    if (st_ff.ir == `INS_IDCODE) begin
                        nxt_st.id_sr = `ID_VALUE;
                    end
                end
                TAP_SHIFT_DR: begin
                    nxt_st.byp = tdi_s;
                    nxt_st.id_sr = {tdi_s, st_ff.id_sr[`ID_W-1:1]};
                end
                default: begin
                end
            endcase
        end
        if (tck_fall) begin
            nxt_st.tdo_oe = (st_ff.state == TAP_SHIFT_IR) || (st_ff.state == TAP_SHIFT_DR);
            if (st_ff.state == TAP_SHIFT_IR) begin
                nxt_st.tdo = st_ff.ir_sr[0];
            end else if (st_ff.state == TAP_SHIFT_DR) begin
                nxt_st.tdo = dr_out;
            end
            if (st_ff.state == TAP_UPD_IR) begin
                nxt_st.ir = st_ff.ir_sr;
            end
        end
        if (!trst_n_s) begin
            nxt_st.state = TAP_TLR;
        end
        if (st_ff.state == TAP_TLR) begin
            nxt_st.ir = `INS_IDCODE;
        end
        // Pin drive: highz wins, then boundary cells, else the core
        if (st_ff.ir == `INS_HIGHZ) begin
            nxt_st.pin_out = core_out;
            nxt_st.pin_oe = 1'b0;
        end else if (cells_drive(st_ff.ir)) begin
            nxt_st.pin_out = bnd_cells[`BND_OUT_MSB:`BND_OUT_LSB];
            nxt_st.pin_oe = bnd_cells[`BND_OE_BIT];
        end else begin
            nxt_st.pin_out = core_out;
            nxt_st.pin_oe = core_oe;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_ff.state <= TAP_TLR;
            st_ff.ir_sr <= `IR_CAPTURE;
            st_ff.ir <= `INS_IDCODE;
            st_ff.byp <= 1'b0;
            st_ff.id_sr <= '0;
            st_ff.tck_prev <= 1'b0;
            st_ff.tdo <= 1'b0;
            st_ff.tdo_oe <= 1'b0;
            st_ff.pin_out <= '0;
            st_ff.pin_oe <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tdo = st_ff.tdo;
    assign tdo_oe = st_ff.tdo_oe;
    assign pin_out = st_ff.pin_out;
    assign pin_oe = st_ff.pin_oe;

    // Helper: rising tck edges seen with tms high in a row, saturating
    logic [2:0] tms_run_ff;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tms_run_ff <= 3'h0;
        end else if (tck_rise) begin
            if (!tms_s) begin
                tms_run_ff <= 3'h0;
            end else if (tms_run_ff != 3'h7) begin
                tms_run_ff <= tms_run_ff + 3'h1;
            end
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sequence s_fall_in_shift_dr;
        tck_fall && (st_ff.state == TAP_SHIFT_DR);
    endsequence

    sequence s_rise_in_cap(tap_t s);
        tck_rise && (st_ff.state == s) && trst_n_s;
    endsequence

    sequence s_fall_in(tap_t s);
        tck_fall && (st_ff.state == s);
    endsequence

    chk_trst_to_reset: assert property (
        !trst_n_s |=> st_ff.state == TAP_TLR ##1 st_ff.ir == `INS_IDCODE)
        else $error("test reset did not reach reset state with id instruction");

    chk_tms_five_high: assert property (
        tms_run_ff >= 3'h5 |-> st_ff.state == TAP_TLR)
        else $error("five high tms cycles did not reset the controller");

    chk_bypass_shift: assert property (
        ((st_ff.ir == `INS_BYPASS) and s_fall_in_shift_dr) |=> tdo == $past(st_ff.byp) && tdo_oe)
        else $error("bypass bit not on tdo");

    chk_bypass_capture: assert property (
        s_rise_in_cap(TAP_CAP_DR) |=> !st_ff.byp)
        else $error("bypass bit did not capture zero");

    chk_ir_update: assert property (
        s_fall_in(TAP_UPD_IR) |=> st_ff.ir == $past(st_ff.ir_sr))
        else $error("instruction not updated from shift stage");

    chk_extest_drive: assert property (
        (st_ff.ir == `INS_EXTEST) |=> pin_out == $past(bnd_cells[`BND_OUT_MSB:`BND_OUT_LSB])
        && pin_oe == $past(bnd_cells[`BND_OE_BIT]))
        else $error("extest does not drive cells");

    chk_extest_path: assert property (
        ((st_ff.ir == `INS_EXTEST) and s_fall_in_shift_dr) |=> tdo == $past(bnd_ser))
        else $error("extest chain not on tdo");

    chk_cells_update: assert property (
        (bnd_sel and s_fall_in(TAP_UPD_DR)) |=> bnd_cells[0] == $past(bnd_ser))
        else $error("update cells did not take the shift cells");

    chk_id_capture: assert property (
        ((st_ff.ir == `INS_IDCODE) and s_rise_in_cap(TAP_CAP_DR))
        |=> st_ff.id_sr == `ID_VALUE && st_ff.id_sr[0])
        else $error("id value not captured");

    chk_id_path: assert property (
        ((st_ff.ir == `INS_IDCODE) and s_fall_in_shift_dr) |=> tdo == $past(st_ff.id_sr[0]))
        else $error("id register not on tdo");

    chk_id_fields: assert property (
        ((st_ff.ir == `INS_IDCODE) and s_rise_in_cap(TAP_CAP_DR))
        |=> st_ff.id_sr[31:28] == `ID_VERSION && st_ff.id_sr[27:12] == `ID_PART
        && st_ff.id_sr[11:1] == `ID_MAKER)
        else $error("id fields out of place");

    chk_highz_off: assert property (
        (st_ff.ir == `INS_HIGHZ) |=> !pin_oe)
        else $error("highz left a driver on");

    chk_highz_path: assert property (
        ((st_ff.ir == `INS_HIGHZ) and s_fall_in_shift_dr) |=> tdo == $past(st_ff.byp))
        else $error("highz path is not the bypass bit");

    chk_clamp_drive: assert property (
        ((st_ff.ir == `INS_CLAMP) and s_fall_in_shift_dr)
        |=> pin_out == $past(bnd_cells[`BND_OUT_MSB:`BND_OUT_LSB]) && tdo == $past(st_ff.byp))
        else $error("clamp path or drive wrong");

    chk_sample_core: assert property (
        (st_ff.ir == `INS_SAMPLE) |=> pin_out == $past(core_out) && pin_oe == $past(core_oe))
        else $error("sample disturbed functional pins");

    chk_sample_capture: assert property (
        bnd_cap |=> bnd_ser == $past(pin_in_s[0]))
        else $error("sample capture lost pin inputs");

    chk_sample_path: assert property (
        ((st_ff.ir == `INS_SAMPLE) and s_fall_in_shift_dr) |=> tdo == $past(bnd_ser))
        else $error("sample chain not on tdo");

    chk_ir_capture: assert property (
        s_rise_in_cap(TAP_CAP_IR) |=> st_ff.ir_sr == `IR_CAPTURE)
        else $error("instruction capture pattern wrong");

    chk_tdo_on_fall: assert property (
        $changed(tdo) |-> $past(tck_fall))
        else $error("tdo changed away from a falling tck");

    chk_tdo_oe_shift: assert property (
        s_fall_in_shift_dr |=> tdo_oe)
        else $error("tdo not enabled while shifting");
endmodule

// *** verilog/scan_port_defines.svh ***
// Constants of the boundary scan test port: codes, widths, cell layout, id value.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SCAN_PORT_DEFINES_SVH
`define SCAN_PORT_DEFINES_SVH

`define IR_W 4
`define ID_W 32
`define INS_EXTEST 4'h0
`define INS_SAMPLE 4'h1
`define INS_IDCODE 4'h2
`define INS_CLAMP 4'h3
`define INS_HIGHZ 4'h4
`define INS_BYPASS 4'hf
`define IR_CAPTURE 4'h1

// Identification fields; version, part and maker values are arbitrary
`define ID_VERSION 4'h1
`define ID_PART 16'h5a5a
`define ID_MAKER 11'h2a5
`define ID_PRESENT 1'h1
`define ID_VALUE {`ID_VERSION, `ID_PART, `ID_MAKER, `ID_PRESENT}

// Boundary cells: functional inputs, functional outputs, one output enable cell
`define BND_IN_W 8
`define BND_OUT_W 8
`define BND_LEN 17
`define BND_OUT_LSB 8
`define BND_OUT_MSB 15
`define BND_OE_BIT 16

// Pin synchroniser: tck, tms, tdi, trst_n, then functional inputs
`define SYNC_W 12
`define TCK_PERIOD_NS 100

`endif

// *** verilog/scan_port_pkg.sv ***
// Types shared by the boundary scan test port modules.
// Assumes scan_port_defines.svh is on the include path.
`include "scan_port_defines.svh"

package scan_port_pkg;

    typedef enum logic [3:0] {
        TAP_TLR = 4'h0,
        TAP_IDLE = 4'h1,
        TAP_SEL_DR = 4'h2,
        TAP_CAP_DR = 4'h3,
        TAP_SHIFT_DR = 4'h4,
        TAP_EXIT1_DR = 4'h5,
        TAP_PAUSE_DR = 4'h6,
        TAP_EXIT2_DR = 4'h7,
        TAP_UPD_DR = 4'h8,
        TAP_SEL_IR = 4'h9,
        TAP_CAP_IR = 4'ha,
        TAP_SHIFT_IR = 4'hb,
        TAP_EXIT1_IR = 4'hc,
        TAP_PAUSE_IR = 4'hd,
        TAP_EXIT2_IR = 4'he,
        TAP_UPD_IR = 4'hf
    } tap_t;

    typedef struct packed {
        logic [`SYNC_W-1:0] s1;
        logic [`SYNC_W-1:0] s2;
    } sync_state_t;

    typedef struct packed {
        logic [`BND_LEN-1:0] sr;
        logic [`BND_LEN-1:0] upd;
    } chain_state_t;

    typedef struct packed {
        tap_t state;
        logic [`IR_W-1:0] ir_sr;
        logic [`IR_W-1:0] ir;
        logic byp;
        logic [`ID_W-1:0] id_sr;
        logic tck_prev;
        logic tdo;
        logic tdo_oe;
        logic [`BND_OUT_W-1:0] pin_out;
        logic pin_oe;
    } port_state_t;

endpackage
